// ===== core/iosc_nco.sv
/*
  iosc_nco: phase accumulator standing in for one oscillator.
  emits a one-cycle tick at the modelled rate while run is high.
  assumes clk_sys, synchronous active-low reset and a global clock enable.
*/
`timescale 1ns/1ps
module iosc_nco #(
  parameter int ACC_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic [ACC_W-1:0] inc,
  // output
  output logic tick
);

  logic [ACC_W-1:0] acc_ff; // phase
  logic [ACC_W-1:0] nxt_acc;
  logic tick_ff; // overflow pulse
  logic nxt_tick;
  logic [ACC_W:0] sum; // carry out marks a period

  // accumulate, restart from zero when stopped
  always_comb begin
    sum = {1'b0, acc_ff} + {1'b0, inc};
    if (run) begin
      nxt_acc = sum[ACC_W-1:0];
      nxt_tick = sum[ACC_W];
    end else begin
      nxt_acc = '0;
      nxt_tick = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : iosc_nco

// ===== core/iosc_pkg.sv
/*
  iosc_pkg: shared constants for the internal oscillator source select block.
  holds register offsets, field positions, reset values, timing counts and
  oscillator model increments. assumes a 100 MHz system clock.
*/
package iosc_pkg;

  // system clock
  localparam int SYS_HZ = 100000000;
  localparam int CLK_PERIOD_NS = 10;

  // register byte offsets, one aligned 32-bit word each
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_TUNE = 4'h4;
  localparam logic [AXI_AW-1:0] REG_STAT = 4'h8;
  localparam logic [AXI_AW-1:0] REG_CFG = 4'hc;

  // control register fields
  localparam int CTRL_SCS_LSB = 0;
  localparam int CTRL_FREQ_LSB = 3;
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [3:0] FREQ_RST = 4'h7;

  // tuning register field
  localparam int TUNE_W = 6;
  localparam logic [TUNE_W-1:0] TUNE_RST = 6'h00;
  localparam int TUNE_SHIFT = 7;

  // status register bit positions
  localparam int STAT_HF_READY = 0;
  localparam int STAT_HF_LOCKED = 1;
  localparam int STAT_HF_STABLE = 2;
  localparam int STAT_MF_READY = 3;
  localparam int STAT_LF_READY = 4;
  localparam int STAT_INT_ACTIVE = 5;

  // config readback bit positions
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_CLKOUT_N = 3;

  // selection codes
  localparam logic [2:0] CFG_INTERNAL = 3'h4;
  localparam logic [1:0] SCS_FROM_CFG = 2'h0;

  // postscaler
  localparam int PS_W = 8;

  // oscillator model: phase accumulator increments
  localparam int ACC_W = 24;
  localparam longint HF_HZ = 16000000;
  localparam longint MF_HZ = 500000;
  localparam longint LF_HZ = 31000;
  localparam logic [ACC_W-1:0] INC_HF = ACC_W'((HF_HZ << ACC_W) / SYS_HZ);
  localparam logic [ACC_W-1:0] INC_MF = ACC_W'((MF_HZ << ACC_W) / SYS_HZ);
  localparam logic [ACC_W-1:0] INC_LF = ACC_W'((LF_HZ << ACC_W) / SYS_HZ);

  // startup times, least times rounded up to whole cycles
  localparam int CNT_W = 10;
  localparam int LF_READY_NS = 1000;
  localparam int MF_READY_NS = 2000;
  localparam int HF_READY_NS = 4000;
  localparam int HF_LOCK_NS = 6000;
  localparam int HF_STABLE_NS = 9000;
  localparam logic [CNT_W-1:0] LF_READY_CYC = CNT_W'((LF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MF_READY_CYC = CNT_W'((MF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_READY_CYC = CNT_W'((HF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_LOCK_CYC = CNT_W'((HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_STABLE_CYC = CNT_W'((HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // the three internal sources
  typedef enum logic [1:0] {IOSC_SRC_LF, IOSC_SRC_MF, IOSC_SRC_HF} iosc_src_t;

endpackage : iosc_pkg

// ===== core/iosc_sel.sv
/*
  iosc_sel: internal oscillator source select with axi4-lite registers.
  models three internal sources, a postscaler/mux, status flags and the
  function of the two oscillator pins. assumes one clock, clk_sys, a
  synchronous active-low reset and a global clock enable.
  // Contract
  // - config internal code selects internal clock at reset
  // - source field 1x switches to internal block
  // - internal mode frees oscillator input pin
  // - output pin gpio or clock, by active-low bit
  // - two oscillators plus loop, three sources
  // - high source 16 MHz from 500 kHz
  // - low source 31 kHz, untrimmed
  // - tuning register trims high and medium sources
  // - frequency field picks high-source derived frequency
  // - frequency field picks medium-source derived frequency
  // - high source enabled on matching select
  // - medium source enabled on matching select
  // - high ready flag while running
  // - high locked flag within 2 percent
  // - high stable flag within 0.5 percent
  // - medium ready flag while running
*/
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module iosc_sel (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // configuration straps, caught while in reset
  input wire logic [2:0] cfg_osc_select,
  input wire logic clock_output_enable_n,
  // axi4-lite write address
  input wire logic [iosc_pkg::AXI_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [iosc_pkg::AXI_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // system clock enable tick and status
  output logic sys_clk_tick,
  output logic internal_oscillator_mode,
  // oscillator pins
  output logic osc_input_pin_release,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe,
  output logic osc_output_pin_release
);
  import iosc_pkg::*;

  // source decode of the frequency field
  function automatic iosc_src_t freq_src(input logic [3:0] f);
    if (f < 4'h2) return IOSC_SRC_LF;
    else if (f < 4'h7) return IOSC_SRC_MF;
    else return IOSC_SRC_HF;
  endfunction : freq_src

  // postscaler divide, as a power of two
  function automatic logic [3:0] freq_div(input logic [3:0] f);
    if (f < 4'h2) return 4'h0;
    else if (f < 4'h7) return 4'h6 - f;
    else return 4'hf - f;
  endfunction : freq_div

  // trimmed increment, about 0.8 percent per step
  function automatic logic [ACC_W-1:0] tuned_inc(input logic [ACC_W-1:0] base, input logic [TUNE_W-1:0] trim);
    logic signed [ACC_W+7:0] step;
    logic signed [ACC_W+7:0] sum;
    step = $signed({8'h00, base >> TUNE_SHIFT}) * $signed({{(ACC_W+8-TUNE_W){trim[TUNE_W-1]}}, trim});
    sum = $signed({8'h00, base}) + step;
    return sum[ACC_W-1:0];
  endfunction : tuned_inc

  // straps
  logic [2:0] cfg_sel_ff;
  logic [2:0] nxt_cfg_sel;
  logic clkout_n_ff;
  logic nxt_clkout_n;
  // software registers
  logic [1:0] scs_ff; // source select field
  logic [1:0] nxt_scs;
  logic [3:0] freq_ff; // frequency select field
  logic [3:0] nxt_freq;
  logic [TUNE_W-1:0] tune_ff;
  logic [TUNE_W-1:0] nxt_tune;
  logic tune_wr; // restarts the loop
  // axi write side
  logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff;
  logic nxt_aw_hold, nxt_w_hold, nxt_awready, nxt_wready, nxt_bvalid;
  logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr, wr_addr;
  logic [31:0] wdata_ff, nxt_wdata, wr_data;
  logic [3:0] wstrb_ff, nxt_wstrb, wr_strb;
  logic [1:0] bresp_ff, nxt_bresp;
  logic aw_take, w_take, wr_fire;
  // axi read side
  logic arready_ff, rvalid_ff, nxt_arready, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic ar_take;
  // oscillator status
  logic [CNT_W-1:0] hf_cnt_ff, mf_cnt_ff, lf_cnt_ff;
  logic [CNT_W-1:0] nxt_hf_cnt, nxt_mf_cnt, nxt_lf_cnt;
  logic hf_ready_ff, hf_locked_ff, hf_stable_ff, mf_ready_ff, lf_ready_ff;
  logic nxt_hf_ready, nxt_hf_locked, nxt_hf_stable, nxt_mf_ready, nxt_lf_ready;
  logic int_active, hf_en, mf_en, lf_en;
  iosc_src_t src;
  logic hf_tick, mf_tick, lf_tick, src_tick;
  // postscaler and outputs
  logic [PS_W-1:0] ps_cnt_ff, nxt_ps_cnt;
  logic [3:0] ps_freq_ff, nxt_ps_freq;
  logic tick_ff, nxt_tick, clkout_ff, nxt_clkout;
  logic int_mode_ff, nxt_int_mode, oe_ff, nxt_oe;

  // source selection, a pure decode of the registers
  always_comb begin
    int_active = scs_ff[1] || (scs_ff == SCS_FROM_CFG && cfg_sel_ff == CFG_INTERNAL);
    src = freq_src(freq_ff);
    hf_en = int_active && src == IOSC_SRC_HF;
    mf_en = int_active && src != IOSC_SRC_LF;
    lf_en = int_active && src == IOSC_SRC_LF;
  end

  // straps follow their pins while reset holds, then freeze
  always_comb begin
    nxt_cfg_sel = cfg_sel_ff;
    nxt_clkout_n = clkout_n_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_sel_ff <= cfg_osc_select;
      clkout_n_ff <= clock_output_enable_n;
    end else if (ce) begin
      cfg_sel_ff <= nxt_cfg_sel;
      clkout_n_ff <= nxt_clkout_n;
    end
  end

  // axi write: address and data taken in either order
  always_comb begin
    aw_take = s_awvalid && awready_ff;
    w_take = s_wvalid && wready_ff;
    wr_addr = aw_take ? s_awaddr : awaddr_ff;
    wr_data = w_take ? s_wdata : wdata_ff;
    wr_strb = w_take ? s_wstrb : wstrb_ff;
    wr_fire = (aw_hold_ff || aw_take) && (w_hold_ff || w_take);
    nxt_awaddr = aw_take ? s_awaddr : awaddr_ff;
    nxt_wdata = w_take ? s_wdata : wdata_ff;
    nxt_wstrb = w_take ? s_wstrb : wstrb_ff;
    nxt_aw_hold = (aw_hold_ff || aw_take) && !wr_fire;
    nxt_w_hold = (w_hold_ff || w_take) && !wr_fire;
    nxt_bvalid = wr_fire || (bvalid_ff && !s_bready);
    nxt_bresp = bresp_ff;
    nxt_scs = scs_ff;
    nxt_freq = freq_ff;
    nxt_tune = tune_ff;
    tune_wr = 1'b0;
    if (wr_fire) begin
      nxt_bresp = 2'h0;
      unique case (wr_addr)
        REG_CTRL: begin
          if (wr_strb[0]) begin
            nxt_scs = wr_data[CTRL_SCS_LSB +: 2];
            nxt_freq = wr_data[CTRL_FREQ_LSB +: 4];
          end
        end
        REG_TUNE: begin
          if (wr_strb[0]) begin
            nxt_tune = wr_data[TUNE_W-1:0];
            tune_wr = 1'b1;
          end
        end
        REG_STAT, REG_CFG: ; // read-only, write ignored
        default: nxt_bresp = 2'h2; // unmapped
      endcase
    end
    // one write at a time: no new beat while a response waits
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready = !nxt_w_hold && !nxt_bvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      scs_ff <= SCS_RST;
      freq_ff <= FREQ_RST;
      tune_ff <= TUNE_RST;
    end else if (ce) begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      scs_ff <= nxt_scs;
      freq_ff <= nxt_freq;
      tune_ff <= nxt_tune;
    end
  end

  // axi read: answer one cycle after the address is taken
  always_comb begin
    ar_take = s_arvalid && arready_ff;
    nxt_rvalid = ar_take || (rvalid_ff && !s_rready);
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_take) begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = 2'h0;
      unique case (s_araddr)
        REG_CTRL: begin
          nxt_rdata[CTRL_SCS_LSB +: 2] = scs_ff;
          nxt_rdata[CTRL_FREQ_LSB +: 4] = freq_ff;
        end
        REG_TUNE: nxt_rdata[TUNE_W-1:0] = tune_ff;
        REG_STAT: begin
          nxt_rdata[STAT_HF_READY] = hf_ready_ff;
          nxt_rdata[STAT_HF_LOCKED] = hf_locked_ff;
          nxt_rdata[STAT_HF_STABLE] = hf_stable_ff;
          nxt_rdata[STAT_MF_READY] = mf_ready_ff;
          nxt_rdata[STAT_LF_READY] = lf_ready_ff;
          nxt_rdata[STAT_INT_ACTIVE] = int_mode_ff;
        end
        REG_CFG: begin
          nxt_rdata[CFG_SEL_LSB +: 3] = cfg_sel_ff;
          nxt_rdata[CFG_CLKOUT_N] = clkout_n_ff;
        end
        default: nxt_rresp = 2'h2; // unmapped reads zero with slverr
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (ce) begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // the three sources; the low one has no trim input
  iosc_nco #(.ACC_W(ACC_W)) u_mf (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .run(mf_en), .inc(tuned_inc(INC_MF, tune_ff)), .tick(mf_tick)
  );
  iosc_nco #(.ACC_W(ACC_W)) u_hf (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .run(hf_en && mf_ready_ff), .inc(tuned_inc(INC_HF, tune_ff)), .tick(hf_tick)
  );
  iosc_nco #(.ACC_W(ACC_W)) u_lf (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .run(lf_en), .inc(INC_LF), .tick(lf_tick)
  );

  // startup timers; the loop only starts once its reference is ready
  always_comb begin
    nxt_mf_cnt = (mf_en && mf_cnt_ff != MF_READY_CYC) ? mf_cnt_ff + 1'b1 : (mf_en ? mf_cnt_ff : '0);
    nxt_lf_cnt = (lf_en && lf_cnt_ff != LF_READY_CYC) ? lf_cnt_ff + 1'b1 : (lf_en ? lf_cnt_ff : '0);
    // a trim change throws the loop out of lock and restarts it
    if (!hf_en || !mf_ready_ff || tune_wr) begin
      nxt_hf_cnt = '0;
    end else if (hf_cnt_ff != HF_STABLE_CYC) begin
      nxt_hf_cnt = hf_cnt_ff + 1'b1;
    end else begin
      nxt_hf_cnt = hf_cnt_ff;
    end
    nxt_mf_ready = mf_en && nxt_mf_cnt == MF_READY_CYC;
    nxt_lf_ready = lf_en && nxt_lf_cnt == LF_READY_CYC;
    nxt_hf_ready = nxt_hf_cnt >= HF_READY_CYC;
    nxt_hf_locked = nxt_hf_cnt >= HF_LOCK_CYC;
    nxt_hf_stable = nxt_hf_cnt >= HF_STABLE_CYC;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hf_cnt_ff <= '0;
      mf_cnt_ff <= '0;
      lf_cnt_ff <= '0;
      hf_ready_ff <= 1'b0;
      hf_locked_ff <= 1'b0;
      hf_stable_ff <= 1'b0;
      mf_ready_ff <= 1'b0;
      lf_ready_ff <= 1'b0;
    end else if (ce) begin
      hf_cnt_ff <= nxt_hf_cnt;
      mf_cnt_ff <= nxt_mf_cnt;
      lf_cnt_ff <= nxt_lf_cnt;
      hf_ready_ff <= nxt_hf_ready;
      hf_locked_ff <= nxt_hf_locked;
      hf_stable_ff <= nxt_hf_stable;
      mf_ready_ff <= nxt_mf_ready;
      lf_ready_ff <= nxt_lf_ready;
    end
  end

  // postscaler and mux; ticks from a source not yet ready are dropped
  always_comb begin
    src_tick = 1'b0;
    unique case (src)
      IOSC_SRC_HF: src_tick = hf_tick && hf_ready_ff;
      IOSC_SRC_MF: src_tick = mf_tick && mf_ready_ff;
      IOSC_SRC_LF: src_tick = lf_tick && lf_ready_ff;
    endcase
    nxt_ps_freq = freq_ff;
    nxt_tick = 1'b0;
    nxt_ps_cnt = ps_cnt_ff;
    if (freq_ff != ps_freq_ff || !int_active) begin
      nxt_ps_cnt = '0; // restart the divider on any reselect
    end else if (src_tick) begin
      if (ps_cnt_ff == PS_W'((1 << freq_div(freq_ff)) - 1)) begin
        nxt_ps_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_ps_cnt = ps_cnt_ff + 1'b1;
      end
    end
    nxt_clkout = nxt_tick ? !clkout_ff : clkout_ff;
    nxt_int_mode = int_active;
    nxt_oe = int_active && !clkout_n_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ps_cnt_ff <= '0;
      ps_freq_ff <= FREQ_RST;
      tick_ff <= 1'b0;
      clkout_ff <= 1'b0;
      int_mode_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (ce) begin
      ps_cnt_ff <= nxt_ps_cnt;
      ps_freq_ff <= nxt_ps_freq;
      tick_ff <= nxt_tick;
      clkout_ff <= nxt_clkout;
      int_mode_ff <= nxt_int_mode;
      oe_ff <= nxt_oe;
    end
  end

  // outputs straight from flops, except osc_output_pin_release, an AND of two
  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
  assign sys_clk_tick = tick_ff;
  assign internal_oscillator_mode = int_mode_ff;
  assign osc_input_pin_release = int_mode_ff;
  assign osc_output_pin_o = clkout_ff;
  assign osc_output_pin_oe = oe_ff;
  assign osc_output_pin_release = int_mode_ff && !oe_ff;

endmodule : iosc_sel

// ===== verification/iosc_sel_monitor.sv
/*
  iosc_sel_monitor: concurrent checks on the ports of iosc_sel.
  assumes one clock, clk_sys, a synchronous active-low rst_n and a master
  that offers write address and data together.
*/
`timescale 1ns/1ps
module iosc_sel_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // configuration strap
  input wire logic [2:0] cfg_osc_select,
  // register bus
  input wire logic [iosc_pkg::AXI_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // mode and pins
  input wire logic internal_oscillator_mode,
  input wire logic osc_input_pin_release,
  input wire logic osc_output_pin_oe,
  input wire logic osc_output_pin_release
);
  import iosc_pkg::*;
  // all checks share the one clock and its reset
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // write to control with the internal source code
  sequence ctrl_to_internal;
    s_awvalid && s_awready && s_wvalid && s_wready && s_awaddr == REG_CTRL && s_wstrb[0] && s_wdata[1];
  endsequence
  // both write channels taken at one edge
  sequence write_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  // read address taken
  sequence read_taken;
    s_arvalid && s_arready;
  endsequence
  a_input_pin_free: assert property (osc_input_pin_release == internal_oscillator_mode)
    else $error("input pin release differs from internal mode");
  a_output_pin_excl: assert property (!(osc_output_pin_oe && osc_output_pin_release))
    else $error("output pin both driven and released");
  a_output_pin_mode: assert property ((osc_output_pin_oe || osc_output_pin_release) == internal_oscillator_mode)
    else $error("output pin function differs from internal mode");
  a_reset_default: assert property ($rose(rst_n) && $past(cfg_osc_select) == CFG_INTERNAL |-> ##[1:2] internal_oscillator_mode)
    else $error("internal strap did not select internal clock after reset");
  a_ctrl_switch: assert property (ctrl_to_internal |-> ##[1:3] internal_oscillator_mode)
    else $error("source field write did not switch to internal clock");
  a_write_answer: assert property (write_taken |=> s_bvalid)
    else $error("write response late");
  a_read_answer: assert property (read_taken |=> s_rvalid && !s_arready)
    else $error("read data late or address still accepted");
  a_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped before taken");
  a_error_zero: assert property (s_rvalid && s_rresp == 2'h2 |-> s_rdata == 32'h0)
    else $error("error read returned nonzero data");
endmodule : iosc_sel_monitor

bind iosc_sel iosc_sel_monitor iosc_sel_monitor_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .cfg_osc_select(cfg_osc_select),
  .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
  .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
  .s_rvalid(s_rvalid), .s_rready(s_rready), .internal_oscillator_mode(internal_oscillator_mode),
  .osc_input_pin_release(osc_input_pin_release), .osc_output_pin_oe(osc_output_pin_oe),
  .osc_output_pin_release(osc_output_pin_release)
);

// ===== verification/tb_internal_osc_source_select.sv
/*
  tb_internal_osc_source_select: self-checking bench for iosc_sel.
  assumes the port monitor is bound from its own file; ce is held high.
*/
`timescale 1ns/1ps
module tb_internal_osc_source_select;
  import iosc_pkg::*;
  // clock, reset, straps
  logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, clock_output_enable_n = 1'b0;
  logic [2:0] cfg_osc_select = 3'h4;
  // bus master drive
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  // design outputs
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sys_clk_tick, internal_oscillator_mode;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic osc_input_pin_release, osc_output_pin_o, osc_output_pin_oe, osc_output_pin_release;
  // bookkeeping
  int bad_count = 0, check_count = 0, nt, ntg;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [3:0] fs [6] = '{4'hf, 4'hb, 4'h7, 4'h6, 4'h2, 4'h0};

  iosc_sel iosc_sel_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cfg_osc_select(cfg_osc_select),
    .clock_output_enable_n(clock_output_enable_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .sys_clk_tick(sys_clk_tick), .internal_oscillator_mode(internal_oscillator_mode),
    .osc_input_pin_release(osc_input_pin_release), .osc_output_pin_o(osc_output_pin_o),
    .osc_output_pin_oe(osc_output_pin_oe), .osc_output_pin_release(osc_output_pin_release));

  // 100 MHz clock
  initial forever #5 clk_sys = ~clk_sys;

  // compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // reset with given straps, held 20 cycles
  task automatic do_reset(input logic [2:0] s, input logic c);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    cfg_osc_select <= s;
    clock_output_enable_n <= c;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset

  // write: each channel released when taken, bready up until answer
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (!aw_done && s_awready === 1'b1) begin
        aw_done = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_done && s_wready === 1'b1) begin
        w_done = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_write

  // read: address held until taken, rready up until data
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk_sys); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_read

  // count system ticks and clock-out toggles over w cycles
  task automatic count_ticks(input int w, output int n, output int g);
    logic p;
    n = 0;
    g = 0;
    p = osc_output_pin_o;
    repeat (w) begin
      @(posedge clk_sys);
      if (sys_clk_tick === 1'b1) n++;
      if (osc_output_pin_o !== p) g++;
      p = osc_output_pin_o;
    end
  endtask : count_ticks

  // internal strap, clock out driven
  task automatic t_reset_state;
    do_reset(3'h4, 1'b0);
    chk("internal mode", 32'h1, internal_oscillator_mode);
    chk("input pin free", 32'h1, osc_input_pin_release);
    chk("clock out drive", 32'h1, osc_output_pin_oe);
    axi_read(REG_CTRL, rd, rsp);
    chk("ctrl reset", {25'h0, FREQ_RST, 1'b0, SCS_RST}, rd);
    axi_read(REG_TUNE, rd, rsp);
    chk("tune reset", 32'h0, rd);
    axi_read(REG_CFG, rd, rsp);
    chk("cfg readback", 32'h4, rd);
    axi_read(REG_STAT, rd, rsp);
    chk("status at start", 32'h20, rd);
    $display("test reset_state done");
  endtask : t_reset_state

  // startup flags, read-only status, tune restart, bad accesses
  task automatic t_status_flags;
    repeat (680) @(posedge clk_sys);
    axi_read(REG_STAT, rd, rsp);
    chk("hf ready only", 32'h29, rd);
    repeat (500) @(posedge clk_sys);
    axi_read(REG_STAT, rd, rsp);
    chk("all flags", 32'h2f, rd);
    axi_write(REG_STAT, 32'h0, 4'hf, rsp);
    axi_read(REG_STAT, rd, rsp);
    chk("status read only", 32'h2f, rd);
    axi_write(REG_TUNE, 32'h5, 4'h1, rsp);
    axi_read(REG_STAT, rd, rsp);
    chk("hf restart", 32'h28, rd);
    axi_read(REG_TUNE, rd, rsp);
    chk("tune value", 32'h5, rd);
    axi_write(4'h2, 32'h3, 4'hf, rsp);
    chk("unmapped write", 32'h2, rsp);
    axi_read(4'h2, rd, rsp);
    chk("unmapped read", 32'h2, {rd[29:0], rsp});
    axi_write(REG_CTRL, 32'h1, 4'h0, rsp);
    axi_read(REG_CTRL, rd, rsp);
    chk("no strobe write", 32'h38, rd);
    $display("test status_flags done");
  endtask : t_status_flags

  // tick rate for each source over six frequency field settings
  task automatic t_freq_rates;
    longint hz;
    int ex;
    axi_write(REG_TUNE, 32'h0, 4'h1, rsp);
    foreach (fs[i]) begin
      axi_write(REG_CTRL, {25'h0, fs[i], 3'h2}, 4'h1, rsp);
      repeat (1500) @(posedge clk_sys);
      count_ticks(4000, nt, ntg);
      hz = fs[i] < 2 ? 31000 : (fs[i] < 7 ? 500000 >> (6 - fs[i]) : 16000000 >> (15 - fs[i]));
      ex = int'(hz * 4000 / 100000000);
      chk("tick count", ex, (nt >= ex - 2 && nt <= ex + 2) ? ex : nt);
      chk("clock out toggles", nt, (ntg - nt <= 1 && nt - ntg <= 1) ? nt : ntg);
    end
    axi_read(REG_STAT, rd, rsp);
    chk("low source only", 32'h30, rd);
    $display("test freq_rates done");
  endtask : t_freq_rates

  // external select, then other strap values
  task automatic t_source_switch;
    axi_write(REG_CTRL, {25'h0, 4'hf, 3'h1}, 4'h1, rsp);
    repeat (3) @(posedge clk_sys);
    chk("external mode", 32'h0, {internal_oscillator_mode, osc_input_pin_release, osc_output_pin_oe});
    axi_read(REG_STAT, rd, rsp);
    chk("flags on disable", 32'h0, rd);
    do_reset(3'h2, 1'b1);
    chk("strap not internal", 32'h0, internal_oscillator_mode);
    axi_read(REG_CFG, rd, rsp);
    chk("cfg strap", 32'ha, rd);
    axi_write(REG_CTRL, {25'h0, 4'h7, 3'h3}, 4'h1, rsp);
    repeat (3) @(posedge clk_sys);
    chk("run-time internal", 32'h5, {internal_oscillator_mode, osc_output_pin_oe, osc_output_pin_release});
    $display("test source_switch done");
  endtask : t_source_switch

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    t_reset_state();
    t_status_flags();
    t_freq_rates();
    t_source_switch();
    complete_run();
  end

  // hang guard, well past the ~34k cycles the tests need
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
endmodule : tb_internal_osc_source_select
